// ### dms_defs.svh
// Constants for the mode switch sequencer: offsets, fields, reset values, timings
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define DMS_OFS_CTRL      8'h00
`define DMS_OFS_STATUS    8'h04
`define DMS_OFS_ERR       8'h08
`define DMS_OFS_MR0       8'h0C
`define DMS_OFS_MR1       8'h10
`define DMS_OFS_MR2       8'h14

// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define DMS_CTRL_CHK_EN   0
`define DMS_CTRL_RST      1'b1
`define DMS_ERR_W         9
`define DMS_MR_RST        16'h0000
`define DMS_ST_DLL_EN     0
`define DMS_ST_LOCKED     1
`define DMS_ST_SELF_REF   2
`define DMS_ST_EXIT_WAIT  3
`define DMS_ST_READY      4
`define DMS_ST_ZQ_BUSY    5
`define DMS_ST_OFF_CFG_OK 6
`define DMS_ST_HOLD       7
`define DMS_ERR_MRD       0
`define DMS_ERR_XS        1
`define DMS_ERR_MOD       2
`define DMS_ERR_ZQ        3
`define DMS_ERR_LOCK      4
`define DMS_ERR_CL        5
`define DMS_ERR_CKE       6
`define DMS_ERR_ODT       7
`define DMS_ERR_ZQ_EARLY  8
`define DMS_RESP_OKAY     2'h0
`define DMS_RESP_SLVERR   2'h2

// ****************************************************************
// Mode register bits
// ****************************************************************
`define DMS_MR1_DLL_DIS   0
`define DMS_MR0_DLL_RST   8
`define DMS_MR1_RTT_A     2
`define DMS_MR1_RTT_B     6
`define DMS_MR1_RTT_C     9
`define DMS_MR2_RTTWR_LO  9
`define DMS_MR2_RTTWR_HI  10
`define DMS_ADDR_AP       10
`define DMS_MR0_CL_MASK   16'h0074
`define DMS_MR0_CL6       16'h0020
`define DMS_MR2_CWL_MASK  16'h0038
`define DMS_MR2_CWL6      16'h0008

// ****************************************************************
// Timings (counts in link clock edges unless in ns)
// ****************************************************************
`define DMS_TMR_W         12
`define DMS_TMRD_NCK      4
`define DMS_TMOD_NCK      12
`define DMS_TXS_NS        170
`define DMS_TCK_NS        80
`define DMS_TDLLK_NCK     512
`define DMS_TZQOPER_NCK   256
`define DMS_NUM_TMR       5
`define DMS_T_MRD         0
`define DMS_T_MOD         1
`define DMS_T_XS          2
`define DMS_T_DLLK        3
`define DMS_T_ZQ          4

`endif

// ### dms_pkg.sv
// Types shared by the mode switch sequencer modules
package dms_pkg;
   typedef enum logic [1:0] {
      DMS_RUN,
      DMS_SELF_REF,
      DMS_EXIT_WAIT
   } dms_state_t;
endpackage

// ### dms_tmr_if.sv
// Link between the sequencer and one of its edge timers
`timescale 1ns/1ps
interface dms_tmr_if #(parameter int W = 12);
   logic         load;
   logic [W-1:0] val;
   logic         tick;
   logic         expired;
   modport tmr (input load, input val, input tick, output expired);
   modport ctl (output load, output val, output tick, input expired);
endinterface

// ### dms_edge_timer.sv
// Down counter of link clock edges; expired means the next edge is legal
`timescale 1ns/1ps
module dms_edge_timer
   import dms_pkg::*;
#(
   parameter int W = 12
) (
   input  wire logic clock_i,
   input  wire logic srst_i,
   dms_tmr_if.tmr    t
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cnt_q <= '0;
      end else if (t.load) begin
         cnt_q <= t.val;
      end else if (t.tick && (cnt_q != '0)) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Count of one left means the edge now arriving is the first legal one
   assign t.expired = (cnt_q[W-1:1] == '0);
endmodule

// ### dms_seq.sv
// DLL mode switch sequencer inside the memory device, with AXI4-Lite status
// Notes on behaviour
// - Long calibration allowed during or after lock, after mode update delay.
// - Next command after update delay; locked-DLL commands wait full lock time.
// - Mode register writes at least four link clock edges apart, counted edges.
// - Nanosecond timings become clock counts by division and rounding up.
// - DLL off needs only read latency six with write latency six.
`timescale 1ns/1ps
`include "dms_defs.svh"
module dms_seq
   import dms_pkg::*;
#(
   parameter int TMRD_NCK    = `DMS_TMRD_NCK,
   parameter int TMOD_NCK    = `DMS_TMOD_NCK,
   parameter int TXS_NS      = `DMS_TXS_NS,
   parameter int TCK_NS      = `DMS_TCK_NS,
   parameter int TDLLK_NCK   = `DMS_TDLLK_NCK,
   parameter int TZQOPER_NCK = `DMS_TZQOPER_NCK
) (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        ck_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [2:0]  ba_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        odt_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic             dll_locked_o,
   output logic             self_refresh_state_o
);
   localparam int TW = `DMS_TMR_W;
   localparam int NT = `DMS_NUM_TMR;
   localparam int PW = 26;
   localparam int TXS_NCK = (TXS_NS + TCK_NS - 1) / TCK_NS;

   // ****************************************************************
   // Pin synchronisers and link clock edge
   // ****************************************************************
   logic [PW-1:0] s1_q;
   logic [PW-1:0] s2_q;
   logic          ck_prev_q;
   logic [PW-1:0] pins;

   assign pins = {ck_i, cke_i, odt_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i};

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s1_q      <= '0;
         s2_q      <= '0;
         ck_prev_q <= 1'b0;
      end else begin
         s1_q      <= pins;
         s2_q      <= s1_q;
         ck_prev_q <= s2_q[25];
      end
   end

   wire        ck_s    = s2_q[25];
   wire        cke_s   = s2_q[24];
   wire        odt_s   = s2_q[23];
   wire        cs_n_s  = s2_q[22];
   wire        ras_n_s = s2_q[21];
   wire        cas_n_s = s2_q[20];
   wire        we_n_s  = s2_q[19];
   wire [2:0]  ba_s    = s2_q[18:16];
   wire [15:0] addr_s  = s2_q[15:0];
   wire        ck_rise = ck_s && !ck_prev_q;

   // ****************************************************************
   // Edge timers
   // ****************************************************************
   logic          tmr_load [NT];
   logic [TW-1:0] tmr_val  [NT];
   logic [NT-1:0] tmr_exp;

   dms_tmr_if #(.W(TW)) tmr_if [NT] ();

   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_tmr
         assign tmr_if[g].load = tmr_load[g];
         assign tmr_if[g].val  = tmr_val[g];
         assign tmr_if[g].tick = ck_rise;
         assign tmr_exp[g]     = tmr_if[g].expired;
         dms_edge_timer #(.W(TW)) u_tmr (
            .clock_i (clock_i),
            .srst_i  (srst_i),
            .t       (tmr_if[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Command decode, sampled at link clock rising edges
   // ****************************************************************
   dms_state_t    state_q;
   dms_state_t    state_d;
   logic          cke_prev_q;
   logic [15:0]   mr0_q;
   logic [15:0]   mr1_q;
   logic [15:0]   mr2_q;
   logic          rst_seen_q;
   logic          hold_q;
   logic          odt_hold_q;
   logic          need_mrs_q;
   logic          chk_en_q;
   logic [`DMS_ERR_W-1:0] err_q;

   wire cmd_sel  = ck_rise && !cs_n_s && cke_prev_q && cke_s;
   wire nop_pat  = ras_n_s && cas_n_s && we_n_s;
   wire is_mrs   = cmd_sel && !ras_n_s && !cas_n_s && !we_n_s;
   wire is_other = cmd_sel && !nop_pat && !is_mrs;
   wire is_zqcl  = is_other && ras_n_s && cas_n_s && !we_n_s && addr_s[`DMS_ADDR_AP];
   wire is_rd    = is_other && ras_n_s && !cas_n_s && we_n_s;
   wire is_sre   = ck_rise && !cs_n_s && cke_prev_q && !cke_s
                   && !ras_n_s && !cas_n_s && we_n_s && (state_q == DMS_RUN);
   wire is_srx   = ck_rise && cke_s && !cke_prev_q && (state_q == DMS_SELF_REF);
   wire wr_mr0   = is_mrs && (ba_s[1:0] == 2'h0);
   wire wr_mr1   = is_mrs && (ba_s[1:0] == 2'h1);
   wire wr_mr2   = is_mrs && (ba_s[1:0] == 2'h2);
   wire dll_rst  = wr_mr0 && addr_s[`DMS_MR0_DLL_RST];
   wire dll_en   = !mr1_q[`DMS_MR1_DLL_DIS];
   wire dll_on_w = wr_mr1 && !addr_s[`DMS_MR1_DLL_DIS] && !dll_en;
   wire odt_feat = mr1_q[`DMS_MR1_RTT_A] || mr1_q[`DMS_MR1_RTT_B] || mr1_q[`DMS_MR1_RTT_C]
                   || mr2_q[`DMS_MR2_RTTWR_LO] || mr2_q[`DMS_MR2_RTTWR_HI];
   wire off_cfg_ok = ((mr0_q & `DMS_MR0_CL_MASK) == `DMS_MR0_CL6)
                     && ((mr2_q & `DMS_MR2_CWL_MASK) == `DMS_MR2_CWL6);
   wire locked   = dll_en && rst_seen_q && tmr_exp[`DMS_T_DLLK];
   wire run_ok   = (state_q == DMS_RUN) && tmr_exp[`DMS_T_MOD] && !need_mrs_q;
   wire release_hold = run_ok && (!dll_en || locked);
   wire cmd_ready = run_ok && tmr_exp[`DMS_T_ZQ];

   // Timer loads
   assign tmr_load[`DMS_T_MRD]  = is_mrs;
   assign tmr_val[`DMS_T_MRD]   = TW'(TMRD_NCK);
   assign tmr_load[`DMS_T_MOD]  = is_mrs;
   assign tmr_val[`DMS_T_MOD]   = TW'(TMOD_NCK);
   assign tmr_load[`DMS_T_XS]   = is_srx;
   assign tmr_val[`DMS_T_XS]    = TW'(TXS_NCK);
   assign tmr_load[`DMS_T_DLLK] = dll_rst;
   assign tmr_val[`DMS_T_DLLK]  = TW'(TDLLK_NCK);
   assign tmr_load[`DMS_T_ZQ]   = is_zqcl;
   assign tmr_val[`DMS_T_ZQ]    = TW'(TZQOPER_NCK);

   // ****************************************************************
   // Sequence state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         DMS_RUN: begin
            if (is_sre) begin
               state_d = DMS_SELF_REF;
            end
         end
         DMS_SELF_REF: begin
            if (is_srx) begin
               state_d = DMS_EXIT_WAIT;
            end
         end
         DMS_EXIT_WAIT: begin
            if (ck_rise && tmr_exp[`DMS_T_XS]) begin
               state_d = DMS_RUN;
            end
         end
         default: begin
            state_d = DMS_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_q    <= DMS_RUN;
         cke_prev_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         cke_prev_q <= ck_rise ? cke_s : cke_prev_q;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mr0_q <= `DMS_MR_RST;
         mr1_q <= `DMS_MR_RST;
         mr2_q <= `DMS_MR_RST;
      end else begin
         mr0_q <= wr_mr0 ? addr_s : mr0_q;
         mr1_q <= wr_mr1 ? addr_s : mr1_q;
         mr2_q <= wr_mr2 ? addr_s : mr2_q;
      end
   end

   // Lock is lost on exit and on re-enable; regained only by a fresh reset
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rst_seen_q <= 1'b0;
      end else if (dll_rst) begin
         rst_seen_q <= 1'b1;
      end else if (is_srx || dll_on_w) begin
         rst_seen_q <= 1'b0;
      end
   end

   // Exit hold window: clock enable high, termination low where needed
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hold_q     <= 1'b0;
         odt_hold_q <= 1'b0;
         need_mrs_q <= 1'b0;
      end else begin
         if (is_srx) begin
            hold_q     <= 1'b1;
            odt_hold_q <= odt_feat;
         end else if (ck_rise && release_hold) begin
            hold_q     <= 1'b0;
            odt_hold_q <= 1'b0;
         end
         if (is_srx) begin
            need_mrs_q <= !dll_en;
         end else if (is_mrs) begin
            need_mrs_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Protocol error detection
   // ****************************************************************
   logic [`DMS_ERR_W-1:0] err_set;
   logic [`DMS_ERR_W-1:0] err_clr;

   always_comb begin
      err_set = '0;
      err_set[`DMS_ERR_MRD] = is_mrs && !tmr_exp[`DMS_T_MRD];
      err_set[`DMS_ERR_XS]  = (is_mrs || is_other) && (state_q == DMS_EXIT_WAIT)
                              && !tmr_exp[`DMS_T_XS];
      err_set[`DMS_ERR_MOD] = is_other && (!tmr_exp[`DMS_T_MOD] || need_mrs_q);
      err_set[`DMS_ERR_ZQ]  = (is_other || is_mrs) && !tmr_exp[`DMS_T_ZQ];
      err_set[`DMS_ERR_LOCK] = is_rd && dll_en && !locked;
      err_set[`DMS_ERR_CL]  = is_rd && !dll_en && !off_cfg_ok;
      err_set[`DMS_ERR_CKE] = ck_rise && hold_q && !cke_s;
      err_set[`DMS_ERR_ODT] = ck_rise && odt_hold_q && odt_s;
      err_set[`DMS_ERR_ZQ_EARLY] = is_zqcl && !tmr_exp[`DMS_T_MOD];
      if (!chk_en_q) begin
         err_set = '0;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   wire        aw_take  = s_axi_awvalid_i && s_axi_awready_o;
   wire        w_take   = s_axi_wvalid_i && s_axi_wready_o;
   wire        do_wr    = aw_hold_q && w_hold_q;
   wire        ar_take  = s_axi_arvalid_i && s_axi_arready_o;
   wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] wbits    = wdata_q & wmask;
   wire        wr_ctrl  = do_wr && (awaddr_q == `DMS_OFS_CTRL);
   wire        wr_err   = do_wr && (awaddr_q == `DMS_OFS_ERR);
   wire        wr_hit   = (awaddr_q == `DMS_OFS_CTRL) || (awaddr_q == `DMS_OFS_ERR);
   wire [31:0] status_w = {24'h000000, hold_q, off_cfg_ok, !tmr_exp[`DMS_T_ZQ], cmd_ready,
                           state_q == DMS_EXIT_WAIT, state_q == DMS_SELF_REF, locked, dll_en};

   logic [31:0] rd_mux;
   logic        rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr_i)
         `DMS_OFS_CTRL:   rd_mux = {31'h00000000, chk_en_q};
         `DMS_OFS_STATUS: rd_mux = status_w;
         `DMS_OFS_ERR:    rd_mux = {{(32-`DMS_ERR_W){1'b0}}, err_q};
         `DMS_OFS_MR0:    rd_mux = {16'h0000, mr0_q};
         `DMS_OFS_MR1:    rd_mux = {16'h0000, mr1_q};
         `DMS_OFS_MR2:    rd_mux = {16'h0000, mr2_q};
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign err_clr = wr_err ? wbits[`DMS_ERR_W-1:0] : '0;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `DMS_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_i;
         end else if (do_wr) begin
            aw_hold_q <= 1'b0;
         end
         if (w_take) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
         end else if (do_wr) begin
            w_hold_q <= 1'b0;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `DMS_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_hit ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // Sticky errors: a new event wins over a clear in the same cycle
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         chk_en_q <= `DMS_CTRL_RST;
         err_q    <= '0;
      end else begin
         chk_en_q <= (wr_ctrl && wstrb_q[0]) ? wdata_q[`DMS_CTRL_CHK_EN] : chk_en_q;
         err_q    <= (err_q & ~err_clr) | err_set;
      end
   end

   assign s_axi_awready_o      = !aw_hold_q && !bvalid_q;
   assign s_axi_wready_o       = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid_o       = bvalid_q;
   assign s_axi_bresp_o        = bresp_q;
   assign s_axi_arready_o      = !rvalid_q;
   assign s_axi_rvalid_o       = rvalid_q;
   assign s_axi_rdata_o        = rdata_q;
   assign s_axi_rresp_o        = rresp_q;
   assign dll_locked_o         = locked;
   assign self_refresh_state_o = (state_q == DMS_SELF_REF);
endmodule

// ### dms_seq_monitor.sv
// Port checker for the mode switch sequencer
`timescale 1ns/1ps
module dms_seq_monitor #(
   parameter int TDLLK_NCK = 16
) (
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rready_i,
   input wire logic        dll_locked_o,
   input wire logic        self_refresh_state_o
);
   localparam int LOCK_CLK = TDLLK_NCK * 16;
   logic [15:0] since_q;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // Cycles since the last self refresh exit
   always_ff @(posedge clock_i) begin
      if (srst_i) since_q <= 16'h0000;
      else if ($fell(self_refresh_state_o)) since_q <= 16'h0000;
      else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
   end
   sequence s_ar_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
   sequence s_b_wait; s_axi_bvalid_o && !s_axi_bready_i; endsequence
   property p_bhold; s_b_wait |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
   property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   property p_arblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   property p_awblk; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
   property p_rlat; s_ar_take |=> s_axi_rvalid_o; endproperty
   property p_resp; s_axi_bvalid_o |-> s_axi_bresp_o inside {2'h0, 2'h2}; endproperty
   property p_srxclr; $fell(self_refresh_state_o) |-> ##[0:2] !dll_locked_o; endproperty
   property p_lockt; $rose(dll_locked_o) |-> since_q >= LOCK_CLK; endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   a_rhold: assert property (p_rhold) else $error("read data dropped early");
   a_arblk: assert property (p_arblk) else $error("read address taken while busy");
   a_awblk: assert property (p_awblk) else $error("write taken while response pending");
   a_rlat: assert property (p_rlat) else $error("read answer late");
   a_resp: assert property (p_resp) else $error("write response code illegal");
   a_srxclr: assert property (p_srxclr) else $error("lock kept over self refresh exit");
   a_lockt: assert property (p_lockt) else $error("lock reported too early");
endmodule

// ### dms_ctl_model.sv
// Memory controller model: link clock and command pins
`timescale 1ns/1ps
module dms_ctl_model #(
   parameter int TCKSRE = 5,
   parameter int TCKSRX = 5
) (
   input  wire logic        clock_i,
   output logic             ck_o,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic             ras_n_o,
   output logic             cas_n_o,
   output logic             we_n_o,
   output logic [2:0]       ba_o,
   output logic [15:0]      addr_o,
   output logic             odt_o
);
   logic [3:0] ph_q = 4'h0;
   logic       run_q = 1'b1;
   always_ff @(posedge clock_i) ph_q <= ph_q + 4'h1;
   // Link clock period is 16 system clocks; pins move on its falling edge
   assign ck_o = run_q & ph_q[3];
   initial begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
      cke_o = 1'b1;
      ba_o = 3'h0;
      addr_o = 16'h0000;
      odt_o = 1'b0;
   end
   task automatic issue(input logic [3:0] c, input logic k, input logic [2:0] b,
                        input logic [15:0] a);
      @(posedge clock_i);
      while (ph_q != 4'hF) @(posedge clock_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      cke_o <= k;
      ba_o <= b;
      addr_o <= a;
      repeat (15) @(posedge clock_i);
   endtask
   // Idle cycles; unused lines toggle every cycle
   task automatic nops(input int n);
      repeat (n) issue(4'h7, cke_o, ~ba_o, ~addr_o);
   endtask
   task automatic self_refresh(input int gap);
      issue(4'h1, 1'b0, 3'h0, 16'h0000);
      repeat (TCKSRE) issue(4'h7, 1'b0, 3'h0, 16'h0000);
      @(posedge clock_i);
      run_q <= 1'b0;
      repeat (gap) @(posedge clock_i);
      @(posedge clock_i);
      while (ph_q != 4'hF) @(posedge clock_i);
      run_q <= 1'b1;
      repeat (TCKSRX) issue(4'h7, 1'b0, 3'h0, 16'h0000);
      issue(4'h7, 1'b1, 3'h0, 16'h0000);
   endtask
endmodule

// ### tb.sv
// Self-checking bench for the mode switch sequencer
`timescale 1ns/1ps
module tb;
   localparam int TDLLK = 16;
   localparam int TZQ   = 8;
   localparam int TXS   = (170 + 79) / 80;
   logic        clock_i, srst_i, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, dll_locked, sr_state;
   logic        ck, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [2:0]  ba;
   logic [15:0] addr;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   int          mismatches, tests_run;
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   dms_seq #(.TDLLK_NCK(TDLLK), .TZQOPER_NCK(TZQ)) u_dut (
      .clock_i(clock_i), .srst_i(srst_i), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .odt_i(odt),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .dll_locked_o(dll_locked),
      .self_refresh_state_o(sr_state));
   dms_ctl_model u_ctl (.clock_i(clock_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .odt_o(odt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge clock_i);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      wstrb <= s;
      @(posedge clock_i);
      while (awvalid || wvalid) begin
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         @(posedge clock_i);
      end
      while (!bvalid) @(posedge clock_i);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
      @(posedge clock_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      @(posedge clock_i);
      while (!arready) @(posedge clock_i);
      arvalid <= 1'b0;
      @(posedge clock_i);
      while (!rvalid) @(posedge clock_i);
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask
   task automatic t_regs;
      rdchk(8'h00, 32'hFFFFFFFF, 32'h1, 2'h0);
      rdchk(8'h04, 32'h3, 32'h1, 2'h0);
      rdchk(8'h08, 32'hFFFFFFFF, 32'h0, 2'h0);
      rdchk(8'hF3, 32'hFFFFFFFF, 32'h0, 2'h2);
      wr(8'h04, 32'h0, 4'hF, 2'h2);
      wr(8'hF3, 32'h0, 4'hF, 2'h2);
   endtask
   task automatic t_off;
      u_ctl.issue(4'h0, 1'b1, 3'h1, 16'h0001);
      u_ctl.nops(11);
      u_ctl.self_refresh(40);
      u_ctl.nops(TXS - 1);
      u_ctl.issue(4'h0, 1'b1, 3'h0, 16'h0020);
      u_ctl.nops(3);
      u_ctl.issue(4'h0, 1'b1, 3'h2, 16'h0008);
      u_ctl.nops(11);
      u_ctl.issue(4'h5, 1'b1, 3'h0, 16'h0000);
      u_ctl.nops(1);
      rdchk(8'h04, 32'h43, 32'h40, 2'h0);
      rdchk(8'h08, 32'hFFFFFFFF, 32'h0, 2'h0);
      rdchk(8'h0C, 32'hFFFF, 32'h20, 2'h0);
   endtask
   task automatic t_on;
      fork
         u_ctl.self_refresh(60);
         begin
            repeat (200) @(posedge clock_i);
            chk({31'h0, sr_state}, 32'h1);
         end
      join
      u_ctl.nops(TXS - 1);
      u_ctl.issue(4'h0, 1'b1, 3'h1, 16'h0000);
      u_ctl.nops(3);
      u_ctl.issue(4'h0, 1'b1, 3'h0, 16'h0100);
      u_ctl.nops(3);
      u_ctl.issue(4'h0, 1'b1, 3'h2, 16'h0008);
      u_ctl.nops(TDLLK - 6);
      chk({31'h0, dll_locked}, 32'h0);
      u_ctl.nops(2);
      chk({31'h0, dll_locked}, 32'h1);
      u_ctl.issue(4'h6, 1'b1, 3'h0, 16'h0400);
      u_ctl.nops(TZQ - 1);
      u_ctl.issue(4'h5, 1'b1, 3'h0, 16'h0000);
      u_ctl.nops(1);
      rdchk(8'h04, 32'h3, 32'h3, 2'h0);
      rdchk(8'h08, 32'hFFFFFFFF, 32'h0, 2'h0);
   endtask
   task automatic t_errs(input logic en);
      wr(8'h00, {31'h0, en}, 4'hF, 2'h0);
      u_ctl.issue(4'h0, 1'b1, 3'h2, 16'h0008);
      u_ctl.nops(2);
      u_ctl.issue(4'h0, 1'b1, 3'h2, 16'h0008);
      u_ctl.issue(4'h6, 1'b1, 3'h0, 16'h0400);
      u_ctl.nops(14);
      rdchk(8'h08, 32'h101, en ? 32'h101 : 32'h0, 2'h0);
      wr(8'h08, 32'h1FF, 4'hE, 2'h0);
      rdchk(8'h08, 32'h101, en ? 32'h1 : 32'h0, 2'h0);
      wr(8'h08, 32'h1FF, 4'h1, 2'h0);
      rdchk(8'h08, 32'hFFFFFFFF, 32'h0, 2'h0);
   endtask
   task automatic conclude;
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      mismatches = 0; tests_run = 0; srst_i = 1'b1;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
      repeat (16) @(posedge clock_i);
      srst_i <= 1'b0;
      t_regs;
      t_off;
      t_on;
      t_errs(1'b1);
      t_errs(1'b0);
      conclude;
   end
   initial begin
      #300000;
      mismatches++;
      conclude;
   end
endmodule
bind dms_seq dms_seq_monitor #(.TDLLK_NCK(TDLLK_NCK)) u_mon (.clock_i(clock_i),
   .srst_i(srst_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rready_i(s_axi_rready_i),
   .dll_locked_o(dll_locked_o), .self_refresh_state_o(self_refresh_state_o));
